// ===== hw/flt_pkg.sv
// Package for the fan lookup table entry seven register bank
package flt_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ThreshAddr = 8'h5C;
  localparam logic [7:0] DutyAddr = 8'h5D;
  localparam logic [7:0] ThreshReset = 8'h7F;
  localparam logic [7:0] DutyReset = 8'h3F;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int ThreshHalfBit = 7;
  localparam int DutyExtHi = 7;
  localparam int DutyExtLo = 6;
  localparam int DutyBaseHi = 5;

  // Register access request
  typedef struct packed {
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } flt_req_t;

  // Operating modes
  typedef struct packed {
    logic tempHiRes;
    logic dutyHiRes;
    logic pwmHighFreq;
    logic tableWrEn;
  } flt_mode_t;
endpackage

// ===== hw/flt_entry7.sv
// Entry seven of the fan lookup table: threshold, duty and compare
// ****************************************
// Overview of operation
// - Low-res temp mode: threshold bit 7 reads zero
// - High-res temp: eight-bit threshold, half degrees
// - Low-res temp: bits 6:0 whole degrees
// - Temperature above threshold drives stored duty
// - Compare nine bits hi-res, eight low-res
// - Threshold is non-negative, sign bit zero
// - Higher thresholds only via separate offset
// - Low-res duty mode: bits 7:6 read zero
// - High-res duty: extended plus base bits
// - Extended duty only at high PWM frequency
// - Low-res PWM uses base six bits
// ****************************************
module flt_entry7 (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire flt_pkg::flt_req_t req,
  input wire flt_pkg::flt_mode_t mode,
  input wire logic [8:0] remoteTemp,
  output logic [7:0] rdata,
  output logic aboveThresh,
  output logic [7:0] dutyOut
);
  import flt_pkg::*;

  // ****************************************
  // Address and write decode
  // ****************************************
  // Writes land only while the table is unlocked
  logic threshHit;
  logic dutyHit;
  logic tableWrOk;
  logic threshWrSel;
  logic dutyWrSel;

  always_comb begin
    threshHit = 1'h0;
    dutyHit = 1'h0;
    if (req.addr == ThreshAddr) begin
      threshHit = 1'h1;
    end else if (req.addr == DutyAddr) begin
      dutyHit = 1'h1;
    end
    tableWrOk = req.wrEn && mode.tableWrEn;
    threshWrSel = tableWrOk && threshHit;
    dutyWrSel = tableWrOk && dutyHit;
  end

  // ****************************************
  // Threshold register
  // ****************************************
  // Whole byte kept; the mode only masks what is shown
  logic [7:0] thresh_r;
  logic [7:0] thresh_nxt;

  always_comb begin
    thresh_nxt = thresh_r;
    if (threshWrSel) begin
      thresh_nxt = req.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      thresh_r <= ThreshReset;
    end else begin
      thresh_r <= thresh_nxt;
    end
  end

  // ****************************************
  // Duty register
  // ****************************************
  // Extended bits kept even while they are masked
  logic [7:0] duty_r;
  logic [7:0] duty_nxt;

  always_comb begin
    duty_nxt = duty_r;
    if (dutyWrSel) begin
      duty_nxt = req.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      duty_r <= DutyReset;
    end else begin
      duty_r <= duty_nxt;
    end
  end

  // ****************************************
  // Stored fields
  // ****************************************
  // Named views of the stored bits
  logic entry7ThresholdHalfBit;
  logic [6:0] entry7ThresholdInteger;
  logic [1:0] entry7DutyExtended;
  logic [5:0] entry7DutyBase;

  assign entry7ThresholdHalfBit = thresh_r[ThreshHalfBit];
  assign entry7ThresholdInteger = thresh_r[ThreshHalfBit - 1:0];
  assign entry7DutyExtended = duty_r[DutyExtHi:DutyExtLo];
  assign entry7DutyBase = duty_r[DutyBaseHi:0];

  // ****************************************
  // Effective fields
  // ****************************************
  // Masking on the way out, never in storage
  logic threshHalfView;
  logic [7:0] threshView;
  logic dutyExtOn;
  logic [1:0] dutyExtView;
  logic [7:0] dutyView;

  always_comb begin
    threshHalfView = 1'h0;
    if (mode.tempHiRes) begin
      threshHalfView = entry7ThresholdHalfBit;
    end
    threshView = {threshHalfView, entry7ThresholdInteger};
    dutyExtOn = mode.dutyHiRes && mode.pwmHighFreq;
    dutyExtView = 2'h0;
    if (dutyExtOn) begin
      dutyExtView = entry7DutyExtended;
    end
    dutyView = {dutyExtView, entry7DutyBase};
  end

  // ****************************************
  // Threshold compare
  // ****************************************
  // Threshold is unsigned; offset handled outside this block
  logic [8:0] threshCmp;
  logic [8:0] tempCmp;
  logic tempAbove;

  always_comb begin
    if (mode.tempHiRes) begin
      // Integer bits above, half-degree bit in LSB
      threshCmp = {1'h0, entry7ThresholdInteger,
        entry7ThresholdHalfBit};
      tempCmp = remoteTemp;
    end else begin
      // Half-degree bit dropped on both sides
      threshCmp = {1'h0, entry7ThresholdInteger, 1'h0};
      tempCmp = {remoteTemp[8:1], 1'h0};
    end
    tempAbove = tempCmp > threshCmp;
  end

  // ****************************************
  // Compare flag
  // ****************************************
  // Flag follows the temperature one clock later
  logic above_r;
  logic above_nxt;

  always_comb begin
    above_nxt = tempAbove;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      above_r <= 1'h0;
    end else begin
      above_r <= above_nxt;
    end
  end

  // ****************************************
  // Duty output
  // ****************************************
  // Shown every cycle; the fan path applies it while above
  logic [7:0] dutyOut_r;
  logic [7:0] dutyOut_nxt;

  always_comb begin
    dutyOut_nxt = dutyView;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dutyOut_r <= 8'h00;
    end else begin
      dutyOut_r <= dutyOut_nxt;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Reads are never gated; unmapped addresses read zero
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb begin
    rdata_nxt = 8'h00;
    if (threshHit) begin
      rdata_nxt = threshView;
    end else if (dutyHit) begin
      rdata_nxt = dutyView;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Output ports
  // ****************************************
  assign aboveThresh = above_r;
  assign dutyOut = dutyOut_r;
  assign rdata = rdata_r;
endmodule

// ===== sim/flt_entry7_chk.sv
// Entry seven port assertions
module flt_entry7_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire flt_pkg::flt_req_t req,
  input wire flt_pkg::flt_mode_t mode,
  input wire logic [8:0] remoteTemp,
  input wire logic [7:0] rdata,
  input wire logic aboveThresh,
  input wire logic [7:0] dutyOut
);
  timeunit 1ns;
  timeprecision 1ps;
  import flt_pkg::*;
  wire t = req.addr == ThreshAddr;
  wire d = req.addr == DutyAddr;
  wire x = mode.dutyHiRes & mode.pwmHighFreq;
  wire w = req.wrEn & mode.tableWrEn;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  AST_LT: assert property ((t & !mode.tempHiRes)[*2] |-> !rdata[7])
    else $error("bit 7 read");
  AST_LD: assert property ((d & !x)[*2] |-> rdata[7:6] == 2'h0)
    else $error("bits 7:6 read");
  AST_NO: assert property ((!t & !d)[*2] |-> rdata == 8'h00)
    else $error("unmapped read");
  AST_ZT: assert property (!$past(|remoteTemp) |-> !aboveThresh)
    else $error("above at zero");
  AST_MT: assert property ($past(rst_b & &remoteTemp) |-> aboveThresh)
    else $error("not above at max");
  AST_EX: assert property (!$past(x) |-> dutyOut[7:6] == 2'h0)
    else $error("duty not masked");
  AST_HD: assert property (!w ##1 (!w & $stable({req.addr, mode}))
    |=> $stable(rdata)) else $error("rdata moved");
  AST_DU: assert property (aboveThresh & $past(d) |-> dutyOut == rdata)
    else $error("duty differs");
endmodule
bind flt_entry7 flt_entry7_chk flt_entry7_chk_inst (.ref_clk, .rst_b, .req,
  .mode, .remoteTemp, .rdata, .aboveThresh, .dutyOut);

// ===== sim/flt_entry7_tb.sv
// Random bench for entry seven
module flt_entry7_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flt_pkg::*;
  logic ref_clk = 0, rst_b = 0, look = 0, aboveThresh, ab;
  flt_req_t req = '0;
  flt_mode_t mode = '0;
  logic [8:0] remoteTemp = '0;
  logic [7:0] rdata, dutyOut, ex, dm, th = ThreshReset, du = DutyReset;
  logic [15:0] r = 16'h0026;
  logic [16:0] q[$];
  int n_errors = 0, total_checks = 0;
  flt_entry7 flt_entry7_inst (.ref_clk, .rst_b, .req, .mode, .remoteTemp,
    .rdata, .aboveThresh, .dutyOut);
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(logic [16:0] seen, logic [16:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    #20000;
    n_errors++;
    end_of_test;
  end
  always @(negedge ref_clk) if (look) chk({rdata, aboveThresh, dutyOut},
    q.pop_front());
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'h1;
    for (int i = 0; i < 300; i++) begin
      @(posedge ref_clk);
      r = lfsr(r);
      look <= 1'h0;
      mode <= r[3:0];
      remoteTemp <= i < 2 ? {9{i[0]}} : r[12:4];
      req <= {r[13], 8'h5C + {6'h00, r[15:14]}, r[11:4]};
      @(posedge ref_clk);
      req.wrEn <= 1'h0;
      if (req.wrEn & mode.tableWrEn & req.addr == ThreshAddr) th = req.wdata;
      if (req.wrEn & mode.tableWrEn & req.addr == DutyAddr) du = req.wdata;
      @(posedge ref_clk);
      dm = mode.dutyHiRes & mode.pwmHighFreq ? du : {2'h0, du[5:0]};
      ab = mode.tempHiRes ? remoteTemp > {1'h0, th[6:0], th[7]} :
        remoteTemp[8:1] > {1'h0, th[6:0]};
      ex = req.addr == DutyAddr ? dm : req.addr != ThreshAddr ? 8'h00 :
        mode.tempHiRes ? th : {1'h0, th[6:0]};
      q.push_back({ex, ab, dm});
      look <= 1'h1;
    end
    @(posedge ref_clk);
    look <= 1'h0;
    @(posedge ref_clk);
    end_of_test;
  end
endmodule
